// ===== logic/acs_defs.svh
// Constants of the amplifier control and status register bank.
// Assumes inclusion by bare name from the design files that need them.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ------------------------------------------------------------------
// Serial bus addressing
// ------------------------------------------------------------------
// Seven-bit slave address; the 8-bit write and read forms are d8 and d9.
`define ACS_SLAVE_ADDR7    7'h6c
// Number of bits in one transferred byte.
`define ACS_BYTE_BITS      4'h8

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define ACS_REG_FAULT      8'h01
`define ACS_REG_STATUS     8'h02
`define ACS_REG_CTRL       8'h03

// ------------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------------
// Latched fault flags clear to zero.
`define ACS_FAULT_RESET    6'h00
// Control: 26 dB gain, 400 kHz switching, limiter off.
`define ACS_CTRL_RESET     8'h78
// Control bits that software can store; reserved bits 2:1 stay zero.
`define ACS_CTRL_WR_MASK   8'hf9

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define ACS_CTRL_FREQ_BIT  0
`define ACS_CTRL_LIM_LSB   3
`define ACS_CTRL_LIM_MSB   5
`define ACS_CTRL_GAIN_LSB  6
`define ACS_CTRL_GAIN_MSB  7
// Number of latched fault flags, held in fault bits 7:2.
`define ACS_FAULT_FLAGS    6

`endif

// ===== logic/acs_pkg.sv
// Types shared by the amplifier control and status register bank.
// Assumes nothing of its surroundings.
package acs_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // Phases of the serial slave.
    typedef enum logic [2:0] {
        ACS_IDLE,
        ACS_ADDR,
        ACS_ACK_ADDR,
        ACS_REG,
        ACS_ACK_WR,
        ACS_WDATA,
        ACS_RDATA,
        ACS_MACK
    } acs_state_type;

    // One register byte.
    typedef logic [7:0] acs_byte_type;
    // Gain select field.
    typedef logic [1:0] acs_gain_type;
    // Peak-output limiter select field.
    typedef logic [2:0] acs_limit_type;

endpackage

// ===== logic/acs_pin_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs come from outside the clk_in domain.
`timescale 1ns/100ps
`default_nettype none

module acs_pin_sync #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] async_in,
    output wire logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("acs_pin_sync needs WIDTH of at least one");
    end

    // ------------------------------------------------------------------
    // Per-bit stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] s1_q;   // First stage, read only by the second.
    logic [WIDTH-1:0] s2_q;   // Second stage.
    logic [WIDTH-1:0] s3_q;   // Third stage.
    logic [WIDTH-1:0] out_q;  // Filtered value.

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        // A change is accepted once the second and third stages agree.
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                s1_q[i]  <= RESET_VAL[i];
                s2_q[i]  <= RESET_VAL[i];
                s3_q[i]  <= RESET_VAL[i];
                out_q[i] <= RESET_VAL[i];
            end else begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    out_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign sync_out = out_q;

endmodule

`default_nettype wire

// ===== logic/acs_fault_latch.sv
// Sticky fault flags: set by an event level, cleared by a read pulse.
// Assumes set and clear inputs are in the clk_in domain.
`timescale 1ns/100ps
`default_nettype none

module acs_fault_latch #(
    parameter int              WIDTH = 6
) (
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic             clear_in,
    output wire logic [WIDTH-1:0] flags_out
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("acs_fault_latch needs WIDTH of at least one");
    end

    // ------------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] flag_q;  // Latched flags.

    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
        // An event in the clearing cycle wins, so none is lost.
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                flag_q[i] <= 1'b0;
            end else if (set_in[i]) begin
                flag_q[i] <= 1'b1;
            end else if (clear_in) begin
                flag_q[i] <= 1'b0;
            end
        end
    end

    assign flags_out = flag_q;

endmodule

`default_nettype wire

// ===== logic/acs_regs.sv
// Control and status register bank of a mono class-D amplifier,
// reached as a slave on a two-wire serial bus.
// Assumes the analog side drives the fault, diagnostic and mode levels,
// and that the board resolves the open-drain data line from its enable.
//
// What this block does
// - Decode 01 fault, 02 status, 03 control.
// - Fault reads zero at reset; bits 1:0 reserved.
// - Fault bits 2-5: diag, overcurrent, under/overvoltage.
// - Fault bit 6 dc offset, 7 overtemperature.
// - Status reads zero when nothing present.
// - Status bits 0-3 show present load faults.
// - Status bits 4-7: fault, diag, mute, play.
// - Control resets to 01111000.
// - Control bit 0 selects 400/500 kHz.
// - Control bits 5:3 select limiter level.
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"

module acs_regs (
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output wire logic                  sda_out,
    output wire logic                  sda_oe_n_out,
    input  wire logic [5:0]            fault_event_in,
    input  wire logic [3:0]            load_diag_in,
    input  wire logic [3:0]            mode_flags_in,
    output wire acs_pkg::acs_gain_type  gain_sel_out,
    output wire acs_pkg::acs_limit_type limit_sel_out,
    output wire logic                  freq_sel_out
);
    import acs_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0]  bus_s;     // Filtered {scl, sda}.
    logic [13:0] ana_s;     // Filtered {mode, diag, fault events}.
    logic        scl_s;     // Clean clock line.
    logic        sda_s;     // Clean data line.
    logic [5:0]  fault_ev;  // Fault events for bits 7:2.
    logic [7:0]  status_w;  // Live status byte.

    // Bus lines idle high, so they reset high to avoid a false start.
    acs_pin_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in ({scl_in, sda_in}),
        .sync_out (bus_s)
    );

    // Analog levels arrive from outside the clock domain too.
    acs_pin_sync #(.WIDTH(14), .RESET_VAL(14'h0000)) u_ana_sync (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .async_in ({mode_flags_in, load_diag_in, fault_event_in}),
        .sync_out (ana_s)
    );

    assign scl_s    = bus_s[1];
    assign sda_s    = bus_s[0];
    assign fault_ev = ana_s[5:0];
    // Live conditions, zero when nothing is present.
    assign status_w = ana_s[13:6];

    // ------------------------------------------------------------------
    // Line edge detection
    // ------------------------------------------------------------------
    logic scl_prev_q;  // Clock line one cycle ago.
    logic sda_prev_q;  // Data line one cycle ago.
    logic scl_rise;    // Clock went high.
    logic scl_fall;    // Clock went low.
    logic start_det;   // Data fell while clock high.
    logic stop_det;    // Data rose while clock high.

    // Both lines pass equal filters, so their order of change holds.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_prev_q;
    assign scl_fall  = ~scl_s & scl_prev_q;
    assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ------------------------------------------------------------------
    // Slave state
    // ------------------------------------------------------------------
    acs_state_type state_q;     // Bus phase.
    logic [3:0]    bit_cnt_q;   // Bits of the current byte.
    acs_byte_type  shift_q;     // Received byte.
    acs_byte_type  tx_q;        // Byte being sent, msb first.
    acs_byte_type  ptr_q;       // Register pointer.
    logic          rd_q;        // Current access is a read.
    logic          mack_q;      // Master answer after a read byte.
    logic          oe_n_q;      // Data line enable, low pulls low.
    logic          sda_zero_q;  // Driven level, always low.
    acs_byte_type  ctrl_q;      // Control register.
    logic [5:0]    flags;       // Latched fault flags 7:2.
    acs_byte_type  fault_w;     // Fault register view.
    acs_byte_type  read_w;      // Byte selected by the pointer.
    logic          byte_done;   // Eighth bit has been clocked.
    logic          load_tx;     // A read byte is fetched now.
    logic          ctrl_wr;     // Control write strobe.
    logic          fault_clr;   // Fault flags are being read.

    assign byte_done = scl_fall && (bit_cnt_q == `ACS_BYTE_BITS);
    assign load_tx   = scl_fall && ((state_q == ACS_ACK_ADDR && rd_q) ||
                                    (state_q == ACS_MACK && !mack_q));
    assign ctrl_wr   = byte_done && state_q == ACS_WDATA &&
                       ptr_q == `ACS_REG_CTRL;
    // Reading the fault register clears it; live faults set again.
    assign fault_clr = load_tx && ptr_q == `ACS_REG_FAULT;
    // Reserved fault bits 1:0 always read zero.
    assign fault_w   = {flags, 2'h0};

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    // Unmapped offsets read as zero.
    always_comb begin
        case (ptr_q)
            `ACS_REG_FAULT:  read_w = fault_w;
            `ACS_REG_STATUS: read_w = status_w;
            `ACS_REG_CTRL:   read_w = ctrl_q;
            default:         read_w = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Serial slave sequencer
    // ------------------------------------------------------------------
    // Samples data on clock rise, changes the data line on clock fall.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q   <= ACS_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            tx_q      <= 8'h00;
            ptr_q     <= 8'h00;
            rd_q      <= 1'b0;
            mack_q    <= 1'b1;
            oe_n_q    <= 1'b1;
        end else if (stop_det) begin
            // Stop ends any transfer and frees the line.
            state_q <= ACS_IDLE;
            oe_n_q  <= 1'b1;
        end else if (start_det) begin
            // Start or repeated start opens an address byte.
            state_q   <= ACS_ADDR;
            bit_cnt_q <= 4'h0;
            oe_n_q    <= 1'b1;
        end else begin
            case (state_q)
                ACS_ADDR, ACS_REG, ACS_WDATA: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == ACS_ADDR) begin
                            if (shift_q[7:1] == `ACS_SLAVE_ADDR7) begin
                                // Acknowledge only our own address.
                                rd_q    <= shift_q[0];
                                oe_n_q  <= 1'b0;
                                state_q <= ACS_ACK_ADDR;
                            end else begin
                                state_q <= ACS_IDLE;
                            end
                        end else if (state_q == ACS_REG) begin
                            ptr_q   <= shift_q;
                            oe_n_q  <= 1'b0;
                            state_q <= ACS_ACK_WR;
                        end else begin
                            // Data bytes auto-increment the pointer.
                            ptr_q   <= ptr_q + 8'h01;
                            oe_n_q  <= 1'b0;
                            state_q <= ACS_ACK_WR;
                        end
                    end
                end
                ACS_ACK_ADDR: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (rd_q) begin
                            // First read byte: drive its msb at once.
                            tx_q    <= read_w;
                            oe_n_q  <= read_w[7];
                            ptr_q   <= ptr_q + 8'h01;
                            state_q <= ACS_RDATA;
                        end else begin
                            oe_n_q  <= 1'b1;
                            state_q <= ACS_REG;
                        end
                    end
                end
                ACS_ACK_WR: begin
                    if (scl_fall) begin
                        oe_n_q  <= 1'b1;
                        state_q <= ACS_WDATA;
                    end
                end
                ACS_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        // Free the line for the master's answer.
                        oe_n_q    <= 1'b1;
                        bit_cnt_q <= 4'h0;
                        state_q   <= ACS_MACK;
                    end else if (scl_fall) begin
                        oe_n_q <= tx_q[6];
                        tx_q   <= {tx_q[6:0], 1'b0};
                    end
                end
                ACS_MACK: begin
                    if (scl_rise) begin
                        mack_q <= sda_s;
                    end else if (scl_fall) begin
                        if (!mack_q) begin
                            // Acknowledged: send the next register.
                            tx_q    <= read_w;
                            oe_n_q  <= read_w[7];
                            ptr_q   <= ptr_q + 8'h01;
                            state_q <= ACS_RDATA;
                        end else begin
                            // Not acknowledged: wait for stop.
                            state_q <= ACS_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ACS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Latched fault flags
    // ------------------------------------------------------------------
    // Events set bits 2..7: diag, overcurrent, under, over, dc, heat.
    acs_fault_latch #(.WIDTH(`ACS_FAULT_FLAGS)) u_fault (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .set_in    (fault_ev),
        .clear_in  (fault_clr),
        .flags_out (flags)
    );

    // ------------------------------------------------------------------
    // Control register and line drive
    // ------------------------------------------------------------------
    // Only offset 03 takes data; reserved bits are masked to zero.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_q <= `ACS_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= shift_q & `ACS_CTRL_WR_MASK;
        end
    end

    // Open-drain: the level is always low, only the enable moves.
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sda_zero_q <= 1'b0;
        end else begin
            sda_zero_q <= 1'b0;
        end
    end

    assign sda_out       = sda_zero_q;
    assign sda_oe_n_out  = oe_n_q;
    assign freq_sel_out  = ctrl_q[`ACS_CTRL_FREQ_BIT];
    assign limit_sel_out = ctrl_q[`ACS_CTRL_LIM_MSB:`ACS_CTRL_LIM_LSB];
    assign gain_sel_out  = ctrl_q[`ACS_CTRL_GAIN_MSB:`ACS_CTRL_GAIN_LSB];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Acknowledge of an address only for the own address.
    property p_addr_ack;
        state_q == ACS_ACK_ADDR |->
            shift_q[7:1] == `ACS_SLAVE_ADDR7 && !oe_n_q;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledged without a match");

    // A fetched control byte equals the control register.
    property p_read_ctrl;
        load_tx && ptr_q == `ACS_REG_CTRL |=> tx_q == $past(ctrl_q);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("control read returned wrong byte");

    // Unmapped offsets fetch zero.
    property p_read_unmapped;
        load_tx && (ptr_q == 8'h00 || ptr_q > `ACS_REG_CTRL) |=> tx_q == 8'h00;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("unmapped read not zero");

    // Reserved fault bits never read set.
    property p_fault_rsvd;
        fault_w[1:0] == 2'h0;
    endproperty
    a_fault_rsvd: assert property (p_fault_rsvd)
        else $error("reserved fault bit set");

    // A load diagnostic event latches fault bit 2 next cycle.
    property p_fault_diag;
        fault_ev[0] |=> fault_w[2];
    endproperty
    a_fault_diag: assert property (p_fault_diag)
        else $error("diagnostic fault not latched");

    // Overtemperature stays latched until a fault read.
    property p_fault_hold;
        fault_w[7] && !fault_clr |=> fault_w[7];
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("overtemperature flag lost");

    // A fetched status byte is the live condition byte.
    property p_read_status;
        load_tx && ptr_q == `ACS_REG_STATUS |=> tx_q == $past(status_w);
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("status read returned wrong byte");

    // Control holds its reset value right after release.
    property p_ctrl_reset;
        $past(reset_in) |-> ctrl_q == `ACS_CTRL_RESET;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset)
        else $error("control reset value wrong");

    // Control changes only through a write.
    property p_ctrl_stable;
        !ctrl_wr |=> $stable(ctrl_q);
    endproperty
    a_ctrl_stable: assert property (p_ctrl_stable)
        else $error("control changed without write");

    // Frequency select follows written bit 0.
    property p_freq;
        ctrl_wr |=> freq_sel_out == $past(shift_q[0]);
    endproperty
    a_freq: assert property (p_freq)
        else $error("frequency select wrong");

    // Limiter select follows written bits 5:3.
    property p_limit;
        ctrl_wr |=> limit_sel_out == $past(shift_q[5:3]);
    endproperty
    a_limit: assert property (p_limit)
        else $error("limiter select wrong");

    // Gain select follows written bits 7:6.
    property p_gain;
        ctrl_wr |=> gain_sel_out == $past(shift_q[7:6]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain select wrong");

endmodule

`default_nettype wire

// ===== testbench/acs_i2c_master.sv
// Behavioural two-wire bus master that reaches the register bank.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module acs_i2c_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic sda_rel_out
);
    // Both lines idle released, so the bus clock stands still between frames.
    initial begin
        scl_out = 1'b1;
        sda_rel_out = 1'b1;
    end
    // A quarter bit time: ten cycles, ending just after a rising edge.
    task automatic wt;
        repeat (10) @(posedge clk_in);
        #1;
    endtask
    // Start or repeated start: data falls while the clock is high.
    task automatic start;
        sda_rel_out = 1'b1;
        wt();
        scl_out = 1'b1;
        wt();
        sda_rel_out = 1'b0;
        wt();
        scl_out = 1'b0;
        wt();
    endtask
    // Stop: data rises while the clock is high.
    task automatic stop;
        sda_rel_out = 1'b0;
        wt();
        scl_out = 1'b1;
        wt();
        sda_rel_out = 1'b1;
        wt();
    endtask
    // One bit: data changes only while the clock is low, sampled mid-high.
    task automatic bit_x(input logic b, output logic r);
        sda_rel_out = b;
        wt();
        scl_out = 1'b1;
        wt();
        r = sda_in;
        wt();
        scl_out = 1'b0;
        wt();
    endtask
    // One byte, most significant bit first, then the acknowledge slot.
    task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
                        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(w[i], r[i]);
        end
        bit_x(last, a);
        ack = !a;
    endtask
endmodule
`default_nettype wire

// ===== testbench/test_amp_control_status_regs.sv
// Self-checking bench of the amplifier register bank over the serial bus.
// Assumes the master model above and the design files under logic/.
`timescale 1ns/100ps
`default_nettype none

module test_amp_control_status_regs;
    import acs_pkg::*;
    logic                clk_in = 1'b0;
    logic                reset_in = 1'b1;
    logic                scl;
    logic                rel;
    logic [5:0]          fev = 6'h00;
    logic [3:0]          ld = 4'h0;
    logic [3:0]          md = 4'h0;
    wire logic           sda;
    wire logic           sda_o;
    wire logic           sda_oe_n;
    wire acs_gain_type   gain;
    wire acs_limit_type  lim;
    wire logic           freq;
    logic [7:0]          q [4];
    logic [7:0]          r;
    logic                a;
    int                  n_fail = 0;
    int                  comparisons = 0;
    // Control rows: written byte, then the byte read back.
    logic [15:0]         rows [8] = '{16'h0701, 16'h4e48, 16'h9191, 16'hdfd9,
                                      16'h2020, 16'h6b69, 16'hb2b0, 16'hf8f8};
    // Pull-up wire: low when either party pulls it.
    assign sda = rel & (sda_oe_n | sda_o);
    always #5 clk_in = ~clk_in;
    acs_regs acs_regs_inst (.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .fault_event_in(fev),
        .load_diag_in(ld), .mode_flags_in(md), .gain_sel_out(gain),
        .limit_sel_out(lim), .freq_sel_out(freq));
    acs_i2c_master acs_i2c_master_inst (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
        .sda_rel_out(rel));
    // Compares and counts; reports a mismatch at once.
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Register write with the address and data acknowledges checked; the pointer acknowledge is not.
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        acs_i2c_master_inst.start();
        acs_i2c_master_inst.xfer(8'hd8, 1'b1, r, a);
        chk("addr ack", {7'h00, a}, 8'h01);
        acs_i2c_master_inst.xfer(p, 1'b1, r, a);
        acs_i2c_master_inst.xfer(d, 1'b1, r, a);
        chk("data ack", {7'h00, a}, 8'h01);
        acs_i2c_master_inst.stop();
    endtask
    // Pointer write, repeated start, then n bytes read with the last refused.
    task automatic rd(input logic [7:0] p, input int n);
        wr_ptr: begin
            acs_i2c_master_inst.start();
            acs_i2c_master_inst.xfer(8'hd8, 1'b1, r, a);
            acs_i2c_master_inst.xfer(p, 1'b1, r, a);
            acs_i2c_master_inst.start();
            acs_i2c_master_inst.xfer(8'hd9, 1'b1, r, a);
            chk("read ack", {7'h00, a}, 8'h01);
        end
        for (int i = 0; i < n; i++) begin
            acs_i2c_master_inst.xfer(8'hff, i == n - 1, q[i], a);
        end
        acs_i2c_master_inst.stop();
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Cuts a hang short, well beyond the expected run of about 39k cycles.
    initial begin
        #1ms;
        n_fail++;
        stop_test();
    end
    // Main sequence: reset, table of control rows, then hand-written cases.
    initial begin
        repeat (8) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        acs_i2c_master_inst.wt();
        chk("gain", {6'h00, gain}, 8'h01);
        chk("limit", {5'h00, lim}, 8'h07);
        chk("freq", {7'h00, freq}, 8'h00);
        rd(8'h01, 4);
        chk("fault", q[0], 8'h00);
        chk("status", q[1], 8'h00);
        chk("control", q[2], 8'h78);
        chk("unmapped", q[3], 8'h00);
        foreach (rows[k]) begin
            wr(8'h03, rows[k][15:8]);
            chk("gain", {6'h00, gain}, {6'h00, rows[k][7:6]});
            chk("limit", {5'h00, lim}, {5'h00, rows[k][5:3]});
            chk("freq", {7'h00, freq}, {7'h00, rows[k][0]});
            rd(8'h03, 1);
            chk("control", q[0], rows[k][7:0]);
        end
        // A brief event per flag; each read also proves the previous flag cleared.
        for (int i = 0; i < 6; i++) begin
            fev = 6'h01 << i;
            acs_i2c_master_inst.wt();
            fev = 6'h00;
            acs_i2c_master_inst.wt();
            rd(8'h01, 1);
            chk("fault", q[0], 8'h04 << i);
        end
        for (int k = 0; k < 2; k++) begin
            {md, ld} = (k == 0) ? 8'h5a : 8'ha5;
            acs_i2c_master_inst.wt();
            rd(8'h02, 1);
            chk("status", q[0], (k == 0) ? 8'h5a : 8'ha5);
        end
        // A foreign address byte must not be acknowledged.
        acs_i2c_master_inst.start();
        acs_i2c_master_inst.xfer(8'hd0, 1'b1, r, a);
        chk("foreign ack", {7'h00, a}, 8'h00);
        acs_i2c_master_inst.stop();
        // A reset in mid-run brings the control byte back to its default.
        reset_in = 1'b1;
        acs_i2c_master_inst.wt();
        reset_in = 1'b0;
        acs_i2c_master_inst.wt();
        chk("gain", {6'h00, gain}, 8'h01);
        rd(8'h03, 1);
        chk("control", q[0], 8'h78);
        stop_test();
    end
endmodule
`default_nettype wire
